// >>> core/pth_pkg.sv
// Constants and types for the pressure threshold and pad control register slice
// Overview of operation
// RULE1 - Threshold is 15-bit unsigned: high byte bits on top of low byte.
// RULE2 - Low threshold register holds bits 7..0, read/write, resets to zero.
// RULE3 - High threshold register holds bits 14..8 in 6..0; bit 7 unused; resets zero.
// RULE4 - Host programs code as threshold in hPa times sixteen.
// RULE5 - Threshold interrupt only with differential enable and high or low enable set.
// RULE6 - Control bit 7 drives interrupt pad as output in second-generation bus mode.
// RULE7 - Control bit 3 connects pull-up on serial data-out pin; reset disconnected.
// RULE8 - Control bit 2 zero keeps interrupt pin pull-down; one disconnects it.
// RULE9 - Control bit 1 disables second-generation two-wire bus protocol; reset enabled.
// RULE10 - Control bit 0 disables I2C; reset leaves SPI and I2C enabled.
// RULE11 - High enable: request when difference exceeds threshold; low enable: when below.
// RULE12 - Difference is measured pressure minus stored reference pressure.
// RULE13 - Control bit 4 connects pull-up on serial data pin; reset disconnected.
// RULE14 - Host writes zero to control bits 6, 5 and high threshold bit 7.
`default_nettype none

package pth_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int         ADDR_W           = 7;
	localparam int         DATA_W           = 8;
	localparam logic [6:0] ADDR_LIMIT_LOW   = 7'h0c;
	localparam logic [6:0] ADDR_LIMIT_HIGH  = 7'h0d;
	localparam logic [6:0] ADDR_PAD_CTRL    = 7'h0e;

	localparam logic [7:0] RST_LIMIT_LOW    = 8'h00;
	localparam logic [7:0] RST_LIMIT_HIGH   = 8'h00;
	localparam logic [7:0] RST_PAD_CTRL     = 8'h00;

	// Writable bits; the rest read as zero
	localparam logic [7:0] MASK_LIMIT_HIGH  = 8'h7f;
	localparam logic [7:0] MASK_PAD_CTRL    = 8'h9f;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int LIMIT_W                  = 15;
	localparam int LIMIT_LOW_W              = 8;
	localparam int BIT_INT_PAD_EN_I3C       = 7;
	localparam int BIT_DATA_PIN_PULLUP      = 4;
	localparam int BIT_DATAOUT_PULLUP       = 3;
	localparam int BIT_IRQ_PULLDOWN_DIS     = 2;
	localparam int BIT_I3C_DISABLE          = 1;
	localparam int BIT_I2C_DISABLE          = 0;

	// ****************************************************************
	// Pressure path
	// ****************************************************************
	localparam int PRESS_W                  = 24;
	localparam int DIFF_W                   = 25;
	// Code steps are 1/16 hPa; shift aligns them to the pressure word LSB
	localparam int LIMIT_ALIGN_SHIFT        = 8;

	typedef enum logic [2:0] {
		RD_IDLE  = 3'b001,
		RD_FETCH = 3'b010,
		RD_DONE  = 3'b100
	} rd_state_t;

endpackage

`default_nettype wire

// >>> core/pth_links_if.sv
// Interfaces carrying threshold compare and pad control signals inside the slice
`default_nettype none

interface compare_link_if;
	logic [14:0] pressure_limit_code;
	logic        differential_irq_enable;
	logic        high_event_enable;
	logic        low_event_enable;
	logic        high_event;
	logic        low_event;
	logic        irq_request;

	modport owner (
		output pressure_limit_code,
		output differential_irq_enable,
		output high_event_enable,
		output low_event_enable,
		input  high_event,
		input  low_event,
		input  irq_request
	);
	modport cmp (
		input  pressure_limit_code,
		input  differential_irq_enable,
		input  high_event_enable,
		input  low_event_enable,
		output high_event,
		output low_event,
		output irq_request
	);
endinterface

interface pad_link_if;
	logic [7:0] pad_ctrl;
	logic       i3c_mode;
	logic       irq_request;
	logic       int_pad_oe;
	logic       int_pad_out;
	logic       int_pulldown_en;
	logic       dataout_pullup_en;
	logic       data_pin_pullup_en;
	logic       i3c_disable;
	logic       i2c_disable;

	modport owner (
		output pad_ctrl,
		output i3c_mode,
		output irq_request,
		input  int_pad_oe,
		input  int_pad_out,
		input  int_pulldown_en,
		input  dataout_pullup_en,
		input  data_pin_pullup_en,
		input  i3c_disable,
		input  i2c_disable
	);
	modport pad (
		input  pad_ctrl,
		input  i3c_mode,
		input  irq_request,
		output int_pad_oe,
		output int_pad_out,
		output int_pulldown_en,
		output dataout_pullup_en,
		output data_pin_pullup_en,
		output i3c_disable,
		output i2c_disable
	);
endinterface

`default_nettype wire

// >>> core/threshold_compare.sv
// Differential pressure against threshold comparator
`default_nettype none

module threshold_compare (
	input  wire logic                        clock_i,
	input  wire logic                        nrst_i,
	input  wire logic                        sample_valid_i,
	input  wire logic [pth_pkg::PRESS_W-1:0] measured_pressure_i,
	input  wire logic [pth_pkg::PRESS_W-1:0] reference_pressure_i,
	compare_link_if.cmp                      link
);

	typedef struct packed {
		logic high_event;
		logic low_event;
	} cmp_state_t;

	cmp_state_t                     state_r;
	cmp_state_t                     state_nxt;
	logic signed [pth_pkg::DIFF_W-1:0] differential_pressure;
	logic signed [pth_pkg::DIFF_W-1:0] limit_aligned;
	logic                           armed;

	always_comb begin
		differential_pressure = $signed({measured_pressure_i[pth_pkg::PRESS_W-1],
			measured_pressure_i}) - $signed({reference_pressure_i[pth_pkg::PRESS_W-1],
			reference_pressure_i}); // RULE12
		limit_aligned = $signed(pth_pkg::DIFF_W'({link.pressure_limit_code,
			pth_pkg::LIMIT_ALIGN_SHIFT'(0)}));
		armed = link.differential_irq_enable
			& (link.high_event_enable | link.low_event_enable); // RULE5
		state_nxt = state_r;
		if (!armed) begin
			state_nxt = '0;
		end else if (sample_valid_i) begin
			state_nxt.high_event = link.high_event_enable
				& (differential_pressure > limit_aligned); // RULE11
			state_nxt.low_event  = link.low_event_enable
				& (differential_pressure < limit_aligned); // RULE11
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign link.high_event  = state_r.high_event;
	assign link.low_event   = state_r.low_event;
	assign link.irq_request = state_r.high_event | state_r.low_event;

endmodule

`default_nettype wire

// >>> core/pad_drive.sv
// Pad and host bus control decode from the interface control byte
`default_nettype none

module pad_drive (
	pad_link_if.pad link
);

	function automatic logic ctrl_bit(input logic [7:0] ctrl, input int pos);
		ctrl_bit = ctrl[pos];
	endfunction

	always_comb begin
		// Outside the second-generation bus mode the pad is an output except during reset
		link.int_pad_oe = link.i3c_mode
			? ctrl_bit(link.pad_ctrl, pth_pkg::BIT_INT_PAD_EN_I3C) : 1'b1; // RULE6
		link.int_pad_out = link.irq_request;
		link.int_pulldown_en =
			!ctrl_bit(link.pad_ctrl, pth_pkg::BIT_IRQ_PULLDOWN_DIS); // RULE8
		link.dataout_pullup_en =
			ctrl_bit(link.pad_ctrl, pth_pkg::BIT_DATAOUT_PULLUP); // RULE7
		link.data_pin_pullup_en =
			ctrl_bit(link.pad_ctrl, pth_pkg::BIT_DATA_PIN_PULLUP); // RULE13
		link.i3c_disable = ctrl_bit(link.pad_ctrl, pth_pkg::BIT_I3C_DISABLE); // RULE9
		link.i2c_disable = ctrl_bit(link.pad_ctrl, pth_pkg::BIT_I2C_DISABLE); // RULE10
	end

endmodule

`default_nettype wire

// >>> core/pressure_threshold_pad_ctrl.sv
// Top of the pressure threshold and interface pad control register slice
`default_nettype none

module pressure_threshold_pad_ctrl (
	input  wire logic                        clock_i,
	input  wire logic                        nrst_i,
	// Register port from the serial interface engine
	input  wire logic                        reg_wr_i,
	input  wire logic                        reg_rd_i,
	input  wire logic [6:0]                  reg_addr_i,
	input  wire logic [7:0]                  reg_wdata_i,
	output var  logic [7:0]                  reg_rdata_o,
	output var  logic                        reg_rvalid_o,
	// Pressure path
	input  wire logic                        sample_valid_i,
	input  wire logic [pth_pkg::PRESS_W-1:0] measured_pressure_i,
	input  wire logic [pth_pkg::PRESS_W-1:0] reference_pressure_i,
	input  wire logic                        differential_irq_enable_i,
	input  wire logic                        high_event_enable_i,
	input  wire logic                        low_event_enable_i,
	input  wire logic                        i3c_mode_i,
	output var  logic [14:0]                 pressure_limit_code_o,
	output var  logic                        high_event_o,
	output var  logic                        low_event_o,
	// Pads
	output var  logic                        first_interrupt_pin_o,
	output var  logic                        first_interrupt_pin_oe_o,
	output var  logic                        irq_pin_pulldown_en_o,
	output var  logic                        dataout_pullup_en_o,
	output var  logic                        data_pin_pullup_en_o,
	output var  logic                        i3c_disable_o,
	output var  logic                        i2c_disable_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0]         limit_low;
		logic [7:0]         limit_high;
		logic [7:0]         pad_ctrl;
		pth_pkg::rd_state_t rd_state;
		logic [6:0]         rd_addr;
		logic [7:0]         rdata;
		logic               rvalid;
		logic [14:0]        limit_code;
		logic               high_event;
		logic               low_event;
		logic               pin_out;
		logic               pin_oe;
		logic               pulldown_en;
		logic               dataout_pu;
		logic               data_pu;
		logic               i3c_dis;
		logic               i2c_dis;
	} top_state_t;

	top_state_t state_r;
	top_state_t state_nxt;

	compare_link_if cmp_link ();
	pad_link_if     pad_link ();

	// Read decode, used only by the fetch stage of the read path
	function automatic logic [7:0] reg_view(input logic [6:0] addr, input top_state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			pth_pkg::ADDR_LIMIT_LOW:  v = s.limit_low;
			pth_pkg::ADDR_LIMIT_HIGH: v = s.limit_high & pth_pkg::MASK_LIMIT_HIGH;
			pth_pkg::ADDR_PAD_CTRL:   v = s.pad_ctrl & pth_pkg::MASK_PAD_CTRL;
			default:                  v = 8'h00;
		endcase
		reg_view = v;
	endfunction

	// ****************************************************************
	// Submodules
	// ****************************************************************
	assign cmp_link.pressure_limit_code     = {state_r.limit_high[6:0], state_r.limit_low}; // RULE1
	assign cmp_link.differential_irq_enable = differential_irq_enable_i;
	assign cmp_link.high_event_enable       = high_event_enable_i;
	assign cmp_link.low_event_enable        = low_event_enable_i;

	threshold_compare u_compare (
		.clock_i              (clock_i),
		.nrst_i               (nrst_i),
		.sample_valid_i       (sample_valid_i),
		.measured_pressure_i  (measured_pressure_i),
		.reference_pressure_i (reference_pressure_i),
		.link                 (cmp_link.cmp)
	);

	assign pad_link.pad_ctrl    = state_r.pad_ctrl;
	assign pad_link.i3c_mode    = i3c_mode_i;
	assign pad_link.irq_request = cmp_link.irq_request;

	pad_drive u_pad (
		.link (pad_link.pad)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		state_nxt.rvalid = 1'b0;

		if (reg_wr_i) begin
			case (reg_addr_i)
				pth_pkg::ADDR_LIMIT_LOW: begin
					state_nxt.limit_low = reg_wdata_i; // RULE2
				end
				pth_pkg::ADDR_LIMIT_HIGH: begin
					// Unused top bit is not stored, so it always reads zero
					state_nxt.limit_high = reg_wdata_i & pth_pkg::MASK_LIMIT_HIGH; // RULE3 RULE14
				end
				pth_pkg::ADDR_PAD_CTRL: begin
					state_nxt.pad_ctrl = reg_wdata_i & pth_pkg::MASK_PAD_CTRL; // RULE14
				end
				default: begin
					state_nxt.pad_ctrl = state_r.pad_ctrl;
				end
			endcase
		end

		// Read is captured one cycle after the strobe so a same-cycle write is seen
		case (state_r.rd_state)
			pth_pkg::RD_IDLE: begin
				if (reg_rd_i) begin
					state_nxt.rd_addr  = reg_addr_i;
					state_nxt.rd_state = pth_pkg::RD_FETCH;
				end
			end
			pth_pkg::RD_FETCH: begin
				state_nxt.rdata    = reg_view(state_r.rd_addr, state_r);
				state_nxt.rvalid   = 1'b1;
				state_nxt.rd_state = pth_pkg::RD_DONE;
			end
			pth_pkg::RD_DONE: begin
				state_nxt.rd_state = pth_pkg::RD_IDLE;
			end
			default: begin
				state_nxt.rd_state = pth_pkg::RD_IDLE;
			end
		endcase

		state_nxt.limit_code  = cmp_link.pressure_limit_code;
		state_nxt.high_event  = cmp_link.high_event;
		state_nxt.low_event   = cmp_link.low_event;
		state_nxt.pin_out     = pad_link.int_pad_out;
		state_nxt.pin_oe      = pad_link.int_pad_oe;
		state_nxt.pulldown_en = pad_link.int_pulldown_en;
		state_nxt.dataout_pu  = pad_link.dataout_pullup_en;
		state_nxt.data_pu     = pad_link.data_pin_pullup_en;
		state_nxt.i3c_dis     = pad_link.i3c_disable;
		state_nxt.i2c_dis     = pad_link.i2c_disable;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			state_r             <= '0;
			state_r.limit_low   <= pth_pkg::RST_LIMIT_LOW; // RULE2
			state_r.limit_high  <= pth_pkg::RST_LIMIT_HIGH; // RULE3
			state_r.pad_ctrl    <= pth_pkg::RST_PAD_CTRL; // RULE10
			state_r.rd_state    <= pth_pkg::RD_IDLE;
			state_r.pulldown_en <= 1'b1; // RULE8
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata_o              = state_r.rdata;
	assign reg_rvalid_o             = state_r.rvalid;
	assign pressure_limit_code_o    = state_r.limit_code;
	assign high_event_o             = state_r.high_event;
	assign low_event_o              = state_r.low_event;
	assign first_interrupt_pin_o    = state_r.pin_out;
	assign first_interrupt_pin_oe_o = state_r.pin_oe;
	assign irq_pin_pulldown_en_o    = state_r.pulldown_en;
	assign dataout_pullup_en_o      = state_r.dataout_pu;
	assign data_pin_pullup_en_o     = state_r.data_pu;
	assign i3c_disable_o            = state_r.i3c_dis;
	assign i2c_disable_o            = state_r.i2c_dis;

endmodule

`default_nettype wire

// >>> test/pth_sva.sv
// Concurrent checks on the ports of the threshold and pad control slice
`default_nettype none

module pth_sva (
	input wire logic                        clock_i,
	input wire logic                        nrst_i,
	input wire logic                        reg_wr_i,
	input wire logic                        reg_rd_i,
	input wire logic [6:0]                  reg_addr_i,
	input wire logic [7:0]                  reg_wdata_i,
	input wire logic                        reg_rvalid_o,
	input wire logic                        sample_valid_i,
	input wire logic [pth_pkg::PRESS_W-1:0] measured_pressure_i,
	input wire logic [pth_pkg::PRESS_W-1:0] reference_pressure_i,
	input wire logic                        differential_irq_enable_i,
	input wire logic                        high_event_enable_i,
	input wire logic                        low_event_enable_i,
	input wire logic                        i3c_mode_i,
	input wire logic [14:0]                 pressure_limit_code_o,
	input wire logic                        high_event_o,
	input wire logic                        low_event_o,
	input wire logic                        first_interrupt_pin_o,
	input wire logic                        first_interrupt_pin_oe_o,
	input wire logic                        irq_pin_pulldown_en_o,
	input wire logic                        dataout_pullup_en_o,
	input wire logic                        data_pin_pullup_en_o,
	input wire logic                        i3c_disable_o,
	input wire logic                        i2c_disable_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Shadow of the writable registers
	// ****************************************************************
	logic [7:0]         lo_r, hi_r, ctrl_r;
	logic signed [24:0] diff_w, thr_w;
	logic               hi_exp_w, lo_exp_w;
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			lo_r <= 8'h00;
			hi_r <= 8'h00;
			ctrl_r <= 8'h00;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				pth_pkg::ADDR_LIMIT_LOW:  lo_r <= reg_wdata_i;
				pth_pkg::ADDR_LIMIT_HIGH: hi_r <= reg_wdata_i & pth_pkg::MASK_LIMIT_HIGH;
				pth_pkg::ADDR_PAD_CTRL:   ctrl_r <= reg_wdata_i & pth_pkg::MASK_PAD_CTRL;
				default:                  lo_r <= lo_r;
			endcase
		end
	end
	assign diff_w = $signed({measured_pressure_i[23], measured_pressure_i})
		- $signed({reference_pressure_i[23], reference_pressure_i});
	assign thr_w = $signed({2'b00, hi_r[6:0], lo_r, 8'h00});
	assign hi_exp_w = diff_w > thr_w;
	assign lo_exp_w = diff_w < thr_w;
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	a_limit_concat: assert property ($past(nrst_i) |->
		pressure_limit_code_o == $past({hi_r[6:0], lo_r}))
		else $error("limit code differs from written bytes");
	// Strobe edge moves to fetch, next edge raises the answer, seen two edges on
	a_read_answer: assert property (reg_rd_i |->
		##1 !reg_rvalid_o ##1 reg_rvalid_o ##1 !reg_rvalid_o)
		else $error("read answer not one pulse two edges on");
	a_disarm_quiet: assert property ((!differential_irq_enable_i ||
		!(high_event_enable_i || low_event_enable_i))[*3] |-> !high_event_o && !low_event_o)
		else $error("event raised while disarmed");
	a_int_pad_oe: assert property ($past(nrst_i) |-> first_interrupt_pin_oe_o ==
		(!$past(i3c_mode_i) || $past(ctrl_r[7]))) else $error("pad enable wrong");
	a_dataout_pullup: assert property ($past(nrst_i) |->
		dataout_pullup_en_o == $past(ctrl_r[3])) else $error("data-out pull-up wrong");
	a_irq_pulldown: assert property ($past(nrst_i) |->
		irq_pin_pulldown_en_o == !$past(ctrl_r[2])) else $error("pin pull-down wrong");
	a_bus2_disable: assert property ($past(nrst_i) |-> i3c_disable_o == $past(ctrl_r[1]))
		else $error("second bus disable wrong");
	a_i2c_disable: assert property ($past(nrst_i) |-> i2c_disable_o == $past(ctrl_r[0]))
		else $error("two-wire disable wrong");
	a_data_pullup: assert property ($past(nrst_i) |->
		data_pin_pullup_en_o == $past(ctrl_r[4])) else $error("data pull-up wrong");
	a_high_compare: assert property (sample_valid_i && differential_irq_enable_i &&
		high_event_enable_i |-> ##2 high_event_o == $past(hi_exp_w, 2)) else $error("high event wrong");
	a_low_compare: assert property (sample_valid_i && differential_irq_enable_i &&
		low_event_enable_i |-> ##2 low_event_o == $past(lo_exp_w, 2)) else $error("low event wrong");
	// Pin and event outputs are both one register behind the comparator flags
	a_pin_from_events: assert property ($past(nrst_i) |-> first_interrupt_pin_o ==
		(high_event_o || low_event_o)) else $error("pin not the event or");
	cover property (high_event_o);
	cover property (low_event_o);
	cover property (reg_rd_i ##2 reg_rvalid_o);
	cover property (i3c_mode_i && first_interrupt_pin_oe_o);
endmodule

bind pressure_threshold_pad_ctrl pth_sva u_pth_sva (.*);

`default_nettype wire

// >>> test/host_model.sv
// Host model driving the register strobe port of the slice
`default_nettype none

module host_model (
	input  wire logic       clock_i,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i,
	output var  logic       reg_wr_o,
	output var  logic       reg_rd_o,
	output var  logic [6:0] reg_addr_o,
	output var  logic [7:0] reg_wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 7'h55;
		reg_wdata_o = 8'haa;
	end
	// Released lines show the inverse so stale values never pass
	task automatic write(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_wr_o <= 1'b1;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge clock_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask
	task automatic read(input logic [6:0] a, output logic [7:0] d);
		d = 8'hxx;
		@(posedge clock_i);
		reg_rd_o <= 1'b1;
		reg_addr_o <= a;
		@(posedge clock_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		// No answer leaves d unknown, so the caller's compare fails
		for (int i = 0; i < 4; i++) begin
			@(posedge clock_i);
			#1;
			if (reg_rvalid_i === 1'b1) begin
				d = reg_rdata_i;
				break;
			end
		end
	endtask
endmodule

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the threshold and pad control slice
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i, nrst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, sample_valid_i, i3c_mode_i;
	logic        differential_irq_enable_i, high_event_enable_i, low_event_enable_i;
	logic [6:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i, reg_rdata_o;
	logic [23:0] measured_pressure_i, reference_pressure_i;
	logic [14:0] pressure_limit_code_o;
	logic        high_event_o, low_event_o, first_interrupt_pin_o, first_interrupt_pin_oe_o;
	logic        irq_pin_pulldown_en_o, dataout_pullup_en_o, data_pin_pullup_en_o;
	logic        i3c_disable_o, i2c_disable_o;
	int          bad_count, samples_checked;
	pressure_threshold_pad_ctrl u_pressure_threshold_pad_ctrl (.*);
	host_model u_host_model (
		.clock_i      (clock_i),
		.reg_rdata_i  (reg_rdata_o),
		.reg_rvalid_i (reg_rvalid_o),
		.reg_wr_o     (reg_wr_i),
		.reg_rd_o     (reg_rd_i),
		.reg_addr_o   (reg_addr_i),
		.reg_wdata_o  (reg_wdata_i)
	);
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic rd_chk(input string name, input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_host_model.read(a, d);
		check(name, d, exp);
	endtask
	task automatic check_pads(input logic [7:0] c);
		repeat (3) @(posedge clock_i);
		#1;
		check("oe", first_interrupt_pin_oe_o, !i3c_mode_i || c[7]);
		check("data_pu", data_pin_pullup_en_o, c[4]);
		check("dout_pu", dataout_pullup_en_o, c[3]);
		check("pin_pd", irq_pin_pulldown_en_o, !c[2]);
		check("bus2_dis", i3c_disable_o, c[1]);
		check("i2c_dis", i2c_disable_o, c[0]);
	endtask
	task automatic sample(input int d, input logic hx, input logic lx);
		@(posedge clock_i);
		sample_valid_i <= 1'b1;
		measured_pressure_i <= 24'h100000 + d[23:0];
		@(posedge clock_i);
		sample_valid_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		check("high_ev", high_event_o, hx);
		check("low_ev", low_event_o, lx);
		@(posedge clock_i);
		#1;
		check("pin", first_interrupt_pin_o, hx || lx);
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_reset();
		check_pads(8'h00);
		rd_chk("low", pth_pkg::ADDR_LIMIT_LOW, 8'h00);
		rd_chk("high", pth_pkg::ADDR_LIMIT_HIGH, 8'h00);
		rd_chk("ctrl", pth_pkg::ADDR_PAD_CTRL, 8'h00);
		check("code", pressure_limit_code_o, 16'h0000);
		$display("test_reset done");
	endtask
	task automatic test_limit();
		logic [14:0] c;
		c = 15'd20 * 15'd16;
		u_host_model.write(pth_pkg::ADDR_LIMIT_LOW, c[7:0]);
		u_host_model.write(pth_pkg::ADDR_LIMIT_HIGH, {1'b0, c[14:8]});
		rd_chk("low", pth_pkg::ADDR_LIMIT_LOW, c[7:0]);
		rd_chk("high", pth_pkg::ADDR_LIMIT_HIGH, {1'b0, c[14:8]});
		check("code", pressure_limit_code_o, {1'b0, c});
		// Top bit of the high byte is unused and must read back zero
		u_host_model.write(pth_pkg::ADDR_LIMIT_HIGH, 8'hff);
		rd_chk("high_ff", pth_pkg::ADDR_LIMIT_HIGH, 8'h7f);
		check("code_ff", pressure_limit_code_o, {1'b0, 7'h7f, c[7:0]});
		$display("test_limit done");
	endtask
	task automatic test_pads();
		logic [7:0] c;
		for (int m = 0; m < 2; m++) begin
			@(posedge clock_i);
			i3c_mode_i <= m[0];
			for (int b = 0; b < 8; b++) begin
				c = (8'h01 << b) & 8'h9f;
				u_host_model.write(pth_pkg::ADDR_PAD_CTRL, c);
				check_pads(c);
				rd_chk("ctrl", pth_pkg::ADDR_PAD_CTRL, c);
			end
		end
		u_host_model.write(pth_pkg::ADDR_PAD_CTRL, 8'hff);
		check_pads(8'h9f);
		u_host_model.write(7'h0f, 8'h00);
		rd_chk("unmapped", 7'h0f, 8'h00);
		rd_chk("ctrl_kept", pth_pkg::ADDR_PAD_CTRL, 8'h9f);
		u_host_model.write(pth_pkg::ADDR_PAD_CTRL, 8'h00);
		i3c_mode_i <= 1'b0;
		$display("test_pads done");
	endtask
	task automatic test_events();
		int ds [3];
		int thr;
		ds = '{5000, 4096, -3000};
		thr = 16 << pth_pkg::LIMIT_ALIGN_SHIFT;
		u_host_model.write(pth_pkg::ADDR_LIMIT_LOW, 8'h10);
		u_host_model.write(pth_pkg::ADDR_LIMIT_HIGH, 8'h00);
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 3; j++) begin
				@(posedge clock_i);
				differential_irq_enable_i <= i[2];
				high_event_enable_i <= i[1];
				low_event_enable_i <= i[0];
				sample(ds[j], i[2] && i[1] && ds[j] > thr, i[2] && i[0] && ds[j] < thr);
			end
		end
		$display("test_events done");
	endtask
	task automatic final_report();
		$display("Checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		#50000;
		bad_count++;
		final_report();
	end
	initial begin
		nrst_i = 1'b0;
		sample_valid_i = 1'b0;
		i3c_mode_i = 1'b0;
		differential_irq_enable_i = 1'b0;
		high_event_enable_i = 1'b0;
		low_event_enable_i = 1'b0;
		measured_pressure_i = 24'h100000;
		reference_pressure_i = 24'h100000;
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		test_reset();
		test_limit();
		test_pads();
		test_events();
		final_report();
	end
endmodule

`default_nettype wire
